// ==== pls_pkg.sv ====
// Package: constants, offsets and types of the live link status block
package pls_pkg;

    // ==========================================
    // Management register map (5-bit register numbers)
    localparam int         PLS_ADDR_W         = 5;
    localparam int         PLS_DATA_W         = 16;
    localparam logic [4:0] PLS_ADDR_PORT_CTL  = 5'h17;
    localparam logic [4:0] PLS_ADDR_LIVE_STAT = 5'h19;

    // ==========================================
    // Port control register fields
    localparam int          PLS_CTL_LINK_EN_BIT = 13;
    localparam logic        PLS_CTL_LINK_EN_RST = 1'h1;

    // ==========================================
    // Live status word field positions
    localparam int PLS_ST_STANDBY   = 15;
    localparam int PLS_ST_FAULT_HI  = 14;
    localparam int PLS_ST_FAULT_LO  = 13;
    localparam int PLS_ST_AN_DONE   = 12;
    localparam int PLS_ST_PAIR_SWAP = 11;
    localparam int PLS_ST_POLARITY  = 10;
    localparam int PLS_ST_SPEED_HI  = 9;
    localparam int PLS_ST_SPEED_LO  = 8;
    localparam int PLS_ST_DUPLEX    = 7;
    localparam int PLS_ST_LINK      = 6;
    localparam int PLS_ST_TX        = 5;
    localparam int PLS_ST_RX        = 4;
    localparam int PLS_ST_COLL      = 3;
    localparam int PLS_ST_AN_BOTH   = 2;
    localparam int PLS_ST_LP_PAUSE  = 1;
    localparam int PLS_ST_LP_ASYM   = 0;

    // ==========================================
    // Field encodings and reset values
    localparam logic [1:0] PLS_FAULT_NONE     = 2'h0;
    localparam logic [1:0] PLS_FAULT_PARALLEL = 2'h1;
    localparam logic [1:0] PLS_FAULT_MS       = 2'h2;
    localparam logic [1:0] PLS_FAULT_RSVD     = 2'h3;
    localparam logic [1:0] PLS_SPEED_10       = 2'h0;
    localparam logic [1:0] PLS_SPEED_100      = 2'h1;
    localparam logic [1:0] PLS_SPEED_1000     = 2'h2;
    localparam logic [1:0] PLS_SPEED_UNDET    = 2'h3;
    localparam logic       PLS_POLARITY_RST   = 1'h1;

    typedef enum logic [1:0] {
        PLS_ST_IDLE,
        PLS_ST_NEGOTIATE,
        PLS_ST_LINKED
    } pls_state_t;

endpackage

// ==== pls_status_if.sv ====
// Interface: live line state carried from the port core to the status word
interface pls_status_if;
    logic       standby;
    logic [1:0] an_fault;
    logic       an_done;
    logic       pair_swap;
    logic       polarity_inv;
    logic [1:0] speed;
    logic       full_duplex;
    logic       link_up;
    logic       tx_active;
    logic       rx_active;
    logic       collision;
    logic       an_both;
    logic       lp_pause;
    logic       lp_asym;
    logic [15:0] word;

    modport core (
        output standby, an_fault, an_done, pair_swap, polarity_inv, speed,
               full_duplex, link_up, tx_active, rx_active, collision,
               an_both, lp_pause, lp_asym,
        input  word
    );
    modport word_side (
        input  standby, an_fault, an_done, pair_swap, polarity_inv, speed,
               full_duplex, link_up, tx_active, rx_active, collision,
               an_both, lp_pause, lp_asym,
        output word
    );
endinterface

// ==== pls_status_word.sv ====
// Status word: registers the live fields into the 16-bit read-only word
module pls_status_word
    import pls_pkg::*;
(
    input  wire logic ref_clk_in,   // Core clock
    input  wire logic rst_in,       // Synchronous reset, active high
    pls_status_if.word_side st      // Live fields in, word out
);

    logic [15:0] word;
    logic [15:0] next_word;

    // ==========================================
    // Word assembly
    always_comb begin
        next_word                   = word;
        next_word[PLS_ST_STANDBY]   = st.standby;
        next_word[PLS_ST_FAULT_HI:PLS_ST_FAULT_LO] = st.an_fault;
        next_word[PLS_ST_AN_DONE]   = st.an_done;
        next_word[PLS_ST_PAIR_SWAP] = st.pair_swap;
        // Polarity is only meaningful at 10 Mb/s; else hold last value
        if (st.link_up && st.speed == PLS_SPEED_10) begin
            next_word[PLS_ST_POLARITY] = st.polarity_inv;
        end
        next_word[PLS_ST_SPEED_HI:PLS_ST_SPEED_LO] = st.speed;
        next_word[PLS_ST_DUPLEX]    = st.full_duplex;
        next_word[PLS_ST_LINK]      = st.link_up;
        next_word[PLS_ST_TX]        = st.tx_active;
        next_word[PLS_ST_RX]        = st.rx_active;
        next_word[PLS_ST_COLL]      = st.collision;
        next_word[PLS_ST_AN_BOTH]   = st.an_both;
        next_word[PLS_ST_LP_PAUSE]  = st.lp_pause;
        next_word[PLS_ST_LP_ASYM]   = st.lp_asym;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            word <= {5'h00, PLS_POLARITY_RST, PLS_SPEED_UNDET, 8'h00};
        end else begin
            word <= next_word;
        end
    end

    assign st.word = word;

endmodule

// ==== pls_link_status.sv ====
// Top: link standby control, management register port and live status word
module pls_link_status
    import pls_pkg::*;
#(
    parameter int ADDR_W = pls_pkg::PLS_ADDR_W,  // Register number width
    parameter int DATA_W = pls_pkg::PLS_DATA_W   // Register data width
) (
    input  wire logic              ref_clk_in,       // Core clock, 50 MHz
    input  wire logic              rst_in,           // Sync reset, high
    // Management register port
    input  wire logic [ADDR_W-1:0] reg_addr_in,      // Register number
    input  wire logic              reg_wr_in,        // Write strobe
    input  wire logic              reg_rd_in,        // Read strobe
    input  wire logic [DATA_W-1:0] reg_wdata_in,     // Write data
    output logic      [DATA_W-1:0] reg_rdata_out,    // Read data
    output logic                   reg_rvalid_out,   // Read data valid
    // Live state from the line side
    input  wire logic              local_an_en_in,   // Local negotiation on
    input  wire logic              partner_an_en_in, // Partner negotiates
    input  wire logic              an_complete_in,   // Negotiation done
    input  wire logic [1:0]        an_fault_in,      // Fault code
    input  wire logic              pair_swap_in,     // Pairs A/B swapped
    input  wire logic              polarity_inv_in,  // Receive inverted
    input  wire logic [1:0]        speed_in,         // Resolved speed
    input  wire logic              full_duplex_in,   // Full duplex
    input  wire logic              link_up_in,       // Link is up
    input  wire logic              tx_active_in,     // Transmitting
    input  wire logic              rx_active_in,     // Receiving
    input  wire logic              collision_in,     // Collision seen
    input  wire logic              lp_pause_in,      // Partner pause
    input  wire logic              lp_asym_pause_in, // Partner asym pause
    // Control toward the line side
    output logic                   standby_out,      // In standby
    output logic                   an_start_out      // Start negotiation
);

    // ==========================================
    // Parameter checks
    // Narrower ports could not carry a register number or the full word
    if (ADDR_W < PLS_ADDR_W) begin : g_addr_chk
        $error("ADDR_W too narrow for register numbers");
    end
    if (DATA_W < PLS_DATA_W) begin : g_data_chk
        $error("DATA_W narrower than the status word");
    end

    // ==========================================
    // Register number decode, shared by the write and read paths
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [4:0]        reg_no);
        addr_hit = (addr == ADDR_W'(reg_no));
    endfunction

    pls_status_if st ();

    // ==========================================
    // Control register: only the link enable bit is held here
    // Writes to any other register number leave link enable untouched
    logic link_enable_ctl;
    logic next_link_enable_ctl;

    always_comb begin
        next_link_enable_ctl = link_enable_ctl;
        if (reg_wr_in && addr_hit(reg_addr_in, PLS_ADDR_PORT_CTL)) begin
            next_link_enable_ctl = reg_wdata_in[PLS_CTL_LINK_EN_BIT];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            link_enable_ctl <= PLS_CTL_LINK_EN_RST;
        end else begin
            link_enable_ctl <= next_link_enable_ctl;
        end
    end

    // ==========================================
    // Port state machine
    // Standby is the idle state: line activity is masked and diagnostics
    // may run. Losing the link while linked restarts negotiation, so the
    // line side always sees a fresh start pulse before the next link.
    pls_state_t state;
    pls_state_t next_state;
    logic       an_start;
    logic       next_an_start;

    always_comb begin
        next_state    = state;
        next_an_start = 1'b0;
        unique case (state)
            PLS_ST_IDLE: begin
                if (link_enable_ctl) begin
                    next_state    = PLS_ST_NEGOTIATE;
                    next_an_start = 1'b1;
                end
            end
            PLS_ST_NEGOTIATE: begin
                if (link_up_in) begin
                    next_state = PLS_ST_LINKED;
                end
            end
            PLS_ST_LINKED: begin
                // Lost link: go back and negotiate again
                if (!link_up_in) begin
                    next_state    = PLS_ST_NEGOTIATE;
                    next_an_start = 1'b1;
                end
            end
        endcase
        if (!link_enable_ctl) begin
            next_state    = PLS_ST_IDLE;
            next_an_start = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state    <= PLS_ST_IDLE;
            an_start <= 1'b0;
        end else begin
            state    <= next_state;
            an_start <= next_an_start;
        end
    end

    // ==========================================
    // Control outputs toward the line side
    logic in_standby;
    logic line_live;
    assign in_standby   = (state == PLS_ST_IDLE);
    assign line_live    = !in_standby && link_up_in;
    assign standby_out  = in_standby;
    assign an_start_out = an_start;

    // ==========================================
    // Live fields; line activity is masked while in standby
    // Speed reads undetermined whenever the link is down, so a stale
    // resolved speed never outlives the link that produced it.
    always_comb begin
        st.standby      = in_standby;
        // Reserved fault code never reaches the word
        st.an_fault     = (in_standby || an_fault_in == PLS_FAULT_RSVD)
                          ? PLS_FAULT_NONE : an_fault_in;
        st.an_done      = !in_standby && an_complete_in;
        st.pair_swap    = line_live && pair_swap_in;
        st.polarity_inv = polarity_inv_in;
        st.speed        = line_live ? speed_in : PLS_SPEED_UNDET;
        st.full_duplex  = line_live && full_duplex_in;
        st.link_up      = line_live;
        st.tx_active    = line_live && tx_active_in;
        st.rx_active    = line_live && rx_active_in;
        st.collision    = line_live && collision_in;
        st.an_both      = !in_standby && local_an_en_in
                          && partner_an_en_in;
        st.lp_pause     = !in_standby && lp_pause_in;
        st.lp_asym      = !in_standby && lp_asym_pause_in;
    end

    // ==========================================
    // Status word register: one edge of lag from the live fields
    pls_status_word u_word (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .st         (st)
    );

    // ==========================================
    // Read path; writes to the status word fall through unused
    // A read and a control write in one cycle return the old link enable;
    // the write lands on the same edge that registers the read data.
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic              rvalid;
    logic              next_rvalid;

    always_comb begin
        next_rdata  = rdata;
        next_rvalid = reg_rd_in;
        if (reg_rd_in) begin
            next_rdata = '0;
            if (addr_hit(reg_addr_in, PLS_ADDR_LIVE_STAT)) begin
                next_rdata[15:0] = st.word;
            end else if (addr_hit(reg_addr_in, PLS_ADDR_PORT_CTL)) begin
                next_rdata[PLS_CTL_LINK_EN_BIT] = link_enable_ctl;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata  <= '0;
            rvalid <= 1'b0;
        end else begin
            rdata  <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // ==========================================
    // Register port outputs
    assign reg_rdata_out  = rdata;
    assign reg_rvalid_out = rvalid;

endmodule

// ==== pls_link_status_asserts.sv ====
// Checker: port-level properties of the live link status block
module pls_link_status_chk
    import pls_pkg::*;
(
    input wire logic        ref_clk_in,     // Clock
    input wire logic        rst_in,         // Reset
    input wire logic [4:0]  reg_addr_in,    // Register number
    input wire logic        reg_wr_in,      // Write strobe
    input wire logic        reg_rd_in,      // Read strobe
    input wire logic [15:0] reg_wdata_in,   // Write data
    input wire logic [15:0] reg_rdata_out,  // Read data
    input wire logic        reg_rvalid_out, // Read valid
    input wire logic        standby_out,    // Standby
    input wire logic        an_start_out    // Start pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    logic rd_st;
    logic wr_ctl;
    assign rd_st  = reg_rd_in && reg_addr_in == PLS_ADDR_LIVE_STAT;
    assign wr_ctl = reg_wr_in && reg_addr_in == PLS_ADDR_PORT_CTL;
    a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    a_no_stray: assert property (!reg_rd_in |=> !reg_rvalid_out)
        else $error("valid without read");
    a_unmapped_zero: assert property (reg_rd_in && !rd_st
        && reg_addr_in != PLS_ADDR_PORT_CTL |=> reg_rdata_out == 16'h0)
        else $error("unmapped read not zero");
    a_standby_mask: assert property (rd_st && !$past(rst_in)
        && $past(standby_out) && standby_out |=> reg_rdata_out == 16'h8300
        || reg_rdata_out == 16'h8700) else $error("standby word wrong");
    a_run_clear: assert property (rd_st && !$past(standby_out)
        && !standby_out |=> !reg_rdata_out[15]) else $error("bit 15 set");
    a_standby_enter: assert property (wr_ctl && !reg_wdata_in[13]
        |-> ##2 standby_out) else $error("standby not entered");
    a_standby_leave: assert property (wr_ctl && reg_wdata_in[13]
        && standby_out && !$past(rst_in) |-> ##2 an_start_out && !standby_out)
        else $error("standby not left");
    a_start_pulse: assert property (an_start_out |=> !an_start_out)
        else $error("start pulse too long");
    a_start_exit: assert property ($fell(standby_out) |-> an_start_out)
        else $error("no start on exit");
    cover property (rd_st ##1 reg_rvalid_out);
    cover property ($rose(standby_out));
    cover property (an_start_out);
endmodule

bind pls_link_status pls_link_status_chk u_chk (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .standby_out(standby_out),
    .an_start_out(an_start_out));

// ==== pls_mgmt_model.sv ====
// Model: management station issuing register reads and writes
module pls_mgmt_model (
    input  wire logic        clk_in,    // Clock
    input  wire logic [15:0] rdata_in,  // Read data
    output logic      [4:0]  addr_out,  // Register number
    output logic             wr_out,    // Write strobe
    output logic             rd_out,    // Read strobe
    output logic      [15:0] wdata_out  // Write data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr_out  = 5'h0A;
        wr_out    = 1'h0;
        rd_out    = 1'h0;
        wdata_out = 16'h5A5A;
    end
    task automatic xfer(input logic w, input logic [4:0] a,
                        input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_in);
        #1;
        addr_out  = a;
        wdata_out = d;
        wr_out    = w;
        rd_out    = !w;
        @(posedge clk_in);
        #1;
        wr_out    = 1'h0;
        rd_out    = 1'h0;
        // Released lines show the inverse so stale values never match
        addr_out  = ~a;
        wdata_out = ~d;
        q         = rdata_in;
    endtask
endmodule

// ==== pls_link_status_test.sv ====
// Testbench: scenarios for the live link status block
module pls_link_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pls_pkg::*;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic [15:0] ln  = 16'h0;
    logic        pol = 1'h1;
    logic        sb  = 1'h0;
    logic [4:0]  addr;
    logic        wr, rd, rv, sby, ans;
    logic [15:0] wdata, rdata;
    int          errors = 0;
    int          num_checks = 0;
    always #10 clk = ~clk;
    pls_mgmt_model pm (.clk_in(clk), .rdata_in(rdata), .addr_out(addr),
        .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
    pls_link_status dut (.ref_clk_in(clk), .rst_in(rst),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rv),
        .local_an_en_in(ln[0]), .partner_an_en_in(ln[1]),
        .an_complete_in(ln[2]), .an_fault_in(ln[4:3]),
        .pair_swap_in(ln[5]), .polarity_inv_in(ln[6]), .speed_in(ln[8:7]),
        .full_duplex_in(ln[9]), .link_up_in(ln[10]),
        .tx_active_in(ln[11]), .rx_active_in(ln[12]),
        .collision_in(ln[13]), .lp_pause_in(ln[14]),
        .lp_asym_pause_in(ln[15]), .standby_out(sby), .an_start_out(ans));
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Expected status word from the line inputs
    function automatic logic [15:0] expw();
        logic lk;
        logic [1:0] f;
        lk = ln[10];
        f  = (ln[4:3] == 2'h3) ? 2'h0 : ln[4:3];
        if (sb) begin
            return {5'h10, pol, 10'h300};
        end
        return {1'h0, f, ln[2], lk & ln[5], pol, lk ? ln[8:7] : 2'h3,
                lk & ln[9], lk, lk & ln[11], lk & ln[12], lk & ln[13],
                ln[0] & ln[1], ln[14], ln[15]};
    endfunction
    task automatic drive(input logic [15:0] v);
        @(posedge clk);
        #1;
        ln = v;
        if (!sb && v[10] && v[8:7] == PLS_SPEED_10) begin
            pol = v[6];
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] q;
        pm.xfer(1'h0, a, 16'h0, q);
        chk(e, q);
        chk(16'h1, {15'h0, rv});
    endtask
    task automatic wrc(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        pm.xfer(1'h1, a, d, q);
    endtask
    task automatic t_reset();
        repeat (2) @(posedge clk);
        rdc(PLS_ADDR_LIVE_STAT, 16'h0700);
        rdc(PLS_ADDR_PORT_CTL, 16'h2000);
    endtask
    task automatic t_standby();
        drive(16'hFFFF);
        wrc(PLS_ADDR_PORT_CTL, 16'hDFFF);
        sb = 1'h1;
        repeat (2) @(posedge clk);
        #1;
        chk(16'h1, {15'h0, sby});
        rdc(PLS_ADDR_LIVE_STAT, expw());
    endtask
    task automatic t_wake();
        wrc(PLS_ADDR_PORT_CTL, 16'h2000);
        sb = 1'h0;
        @(posedge clk);
        #1;
        chk(16'h2, {14'h0, ans, sby});
        @(posedge clk);
        #1;
        chk(16'h0, {14'h0, ans, sby});
    endtask
    task automatic t_fields();
        logic [15:0] tv [7] = '{16'h0000, 16'h0413, 16'h4C4D, 16'hB6A2,
                                16'h7D18, 16'h3BFF, 16'hFFFF};
        foreach (tv[i]) begin
            drive(tv[i]);
            rdc(
                PLS_ADDR_LIVE_STAT,
                expw());
        end
    endtask
    task automatic t_ro();
        wrc(PLS_ADDR_LIVE_STAT, 16'h0000);
        rdc(PLS_ADDR_LIVE_STAT, expw());
        wrc(5'h1F, 16'hFFFF);
        rdc(5'h1F, 16'h0000);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'h0;
        t_reset();
        t_standby();
        t_wake();
        t_fields();
        t_ro();
        summarize();
    end
    initial begin
        #100000;
        errors++;
        summarize();
    end
endmodule
